// File: design/fpep_pkg.sv
/*
 * Shared constants for the flash program/erase protection block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 250 MHz system clock and a 32-bit classic Wishbone bus.
 */
package fpep_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_FLASH_CTRL = 8'h00;
	localparam logic [7:0] OFS_EBS_UPPER = 8'h04;
	localparam logic [7:0] OFS_EBS_LOWER = 8'h08;
	localparam logic [7:0] OFS_WAIT_STATE = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Register index returned by the address decoder
	typedef enum logic [4:0] {
		FPEP_REG_CTRL = 5'h01,
		FPEP_REG_EBSU = 5'h02,
		FPEP_REG_EBSL = 5'h04,
		FPEP_REG_WSC = 5'h08,
		FPEP_REG_STAT = 5'h10
	} fpep_reg_t;
	localparam logic [4:0] FPEP_REG_NONE = 5'h00;

	// Flash control register fields
	localparam int BIT_PROG = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_PROG_VERIFY = 2;
	localparam int BIT_ERASE_VERIFY = 3;
	localparam int BIT_PROG_ACTIVE = 4;
	localparam int BIT_ERASE_ACTIVE = 5;
	localparam int BIT_ABORTED = 6;
	localparam int BIT_VPP_HIGH = 7;

	// Wait-state control register fields
	localparam int BIT_OVL_HI = 7;
	localparam int BIT_OVL_LO = 6;

	// Status register fields
	localparam int BIT_PREWRITE_VERIFY = 0;
	localparam int BIT_PREWRITE_SETTLED = 1;
	localparam int BIT_EMUL_PROTECT = 2;

	// Reset values
	localparam logic [3:0] RST_FLASH_CTRL = 4'h0;
	localparam logic [7:0] RST_EBS = 8'h00;
	localparam logic [7:0] RST_WAIT_STATE = 8'h08;

	// Prewrite-verify settling time, rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 4;
	localparam int PWV_SETTLE_NS = 4000;
	localparam int PWV_SETTLE_CYC = (PWV_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] PWV_SETTLE_CNT = PWV_SETTLE_CYC[10:0];
endpackage : fpep_pkg

// File: design/fpep_sync.sv
/*
 * Two-flop synchroniser for asynchronous pin levels.
 * Assumes the inputs are slow levels; pulses shorter than a clock may vanish.
 */
`timescale 1ns/1ps
`default_nettype none
module fpep_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Level to synchronise and its reset value
	input wire logic [WIDTH-1:0] async_i,
	input wire logic [WIDTH-1:0] init_i,
	// Synchronised level
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// First stage feeds only the second stage; reset loads a known level so that
	// no unknown pin level reaches the reset logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= init_i;
			sync_ff <= init_i;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule : fpep_sync
`default_nettype wire

// File: design/fpep_top.sv
/*
 * Protection and verify-mode logic for an on-chip flash program/erase
 * controller, with its control registers on a classic Wishbone slave.
 * Assumes one 250 MHz clock; the programming-voltage and chip clear pins
 * are asynchronous, interrupt, standby and watchdog reset come from logic
 * on the same clock.
 */
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fpep_top
	import fpep_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins and system events
	input wire logic program_voltage_pin_i,
	input wire logic chip_clear_pin_n_i,
	input wire logic watchdog_reset_i,
	input wire logic standby_i,
	input wire logic irq_i,
	// Flash array control
	output logic program_enable_o,
	output logic erase_enable_o,
	output logic program_verify_o,
	output logic erase_verify_o,
	output logic prewrite_verify_o,
	output logic [15:0] block_enable_o,
	output logic [1:0] overlay_select_o
);
	logic [1:0] pins_sync;
	logic vpp_ok;
	logic chip_clear;
	logic any_reset;
	logic hw_clear;
	logic [3:0] flash_control_reg_ff;
	logic [7:0] erase_block_select_upper_ff;
	logic [7:0] erase_block_select_lower_ff;
	logic [7:0] wait_state_control_reg_ff;
	logic abort_ff;
	logic [10:0] settle_cnt_ff;
	logic ack_ff;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic [4:0] reg_hit;
	logic wr_cyc;
	logic emul_protect;
	logic block_protect;
	logic pe_allowed;
	logic pwv_mode;
	logic settled;

	// Map a byte address onto a register index
	function automatic logic [4:0] decode_reg(input logic [7:0] adr);
		unique case (adr)
			OFS_FLASH_CTRL: decode_reg = FPEP_REG_CTRL;
			OFS_EBS_UPPER: decode_reg = FPEP_REG_EBSU;
			OFS_EBS_LOWER: decode_reg = FPEP_REG_EBSL;
			OFS_WAIT_STATE: decode_reg = FPEP_REG_WSC;
			OFS_STATUS: decode_reg = FPEP_REG_STAT;
			default: decode_reg = FPEP_REG_NONE;
		endcase
	endfunction : decode_reg

	// Pin levels cross into the clock domain before use
	fpep_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({program_voltage_pin_i, chip_clear_pin_n_i}),
		.init_i(2'h1),
		.sync_o(pins_sync)
	);

	// Reset sources; a short chip clear pulse may be missed by the synchroniser
	assign vpp_ok = pins_sync[1];
	assign chip_clear = ~pins_sync[0];
	assign any_reset = rst_i | watchdog_reset_i | chip_clear;
	assign hw_clear = any_reset | standby_i | ~vpp_ok;

	// Bus request decode; writes land on the edge where ack is sampled
	assign reg_hit = decode_reg(wb_adr_i);
	assign wr_cyc = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];

	// Flash control register, frozen after an abort
	always_ff @(posedge clk_i) begin
		if (hw_clear) begin
			flash_control_reg_ff <= RST_FLASH_CTRL;
		end else if (wr_cyc && reg_hit == FPEP_REG_CTRL && !abort_ff) begin
			flash_control_reg_ff <= wb_dat_i[3:0];
		end
	end

	// Block select registers, frozen after an abort
	always_ff @(posedge clk_i) begin
		if (hw_clear) begin
			erase_block_select_upper_ff <= RST_EBS;
			erase_block_select_lower_ff <= RST_EBS;
		end else if (wr_cyc && !abort_ff) begin
			if (reg_hit == FPEP_REG_EBSU) begin
				erase_block_select_upper_ff <= wb_dat_i[7:0];
			end
			if (reg_hit == FPEP_REG_EBSL) begin
				erase_block_select_lower_ff <= wb_dat_i[7:0];
			end
		end
	end

	// Wait-state control holds the overlay selects; voltage does not clear it
	always_ff @(posedge clk_i) begin
		if (any_reset || standby_i) begin
			wait_state_control_reg_ff <= RST_WAIT_STATE;
		end else if (wr_cyc && reg_hit == FPEP_REG_WSC) begin
			wait_state_control_reg_ff <= wb_dat_i[7:0];
		end
	end

	// Protection terms
	assign emul_protect = wait_state_control_reg_ff[BIT_OVL_HI] ^
		wait_state_control_reg_ff[BIT_OVL_LO];
	assign block_protect = ({erase_block_select_upper_ff, erase_block_select_lower_ff} ==
		16'h0000);
	assign pe_allowed = vpp_ok & ~standby_i & ~abort_ff & ~emul_protect &
		~block_protect;

	// Program and erase are exclusive; both bits set enters neither
	assign program_enable_o = pe_allowed & flash_control_reg_ff[BIT_PROG] &
		~flash_control_reg_ff[BIT_ERASE];
	assign erase_enable_o = pe_allowed & flash_control_reg_ff[BIT_ERASE] &
		~flash_control_reg_ff[BIT_PROG];
	assign block_enable_o = {erase_block_select_upper_ff, erase_block_select_lower_ff} &
		{16{pe_allowed}};

	// Verify modes stay usable under software and interrupt protection
	assign program_verify_o = vpp_ok & flash_control_reg_ff[BIT_PROG_VERIFY];
	assign erase_verify_o = vpp_ok & flash_control_reg_ff[BIT_ERASE_VERIFY];
	assign pwv_mode = vpp_ok & ~standby_i & (flash_control_reg_ff == 4'h0);
	assign prewrite_verify_o = pwv_mode;
	assign overlay_select_o = {wait_state_control_reg_ff[BIT_OVL_HI],
		wait_state_control_reg_ff[BIT_OVL_LO]};

	// Interrupt abort is sticky; only a reset releases it
	always_ff @(posedge clk_i) begin
		if (any_reset) begin
			abort_ff <= 1'b0;
		end else if (irq_i && (program_enable_o || erase_enable_o)) begin
			abort_ff <= 1'b1;
		end
	end

	// Settling timer lets software poll instead of counting loops
	always_ff @(posedge clk_i) begin
		if (hw_clear || !pwv_mode) begin
			settle_cnt_ff <= 11'h000;
		end else if (settle_cnt_ff != PWV_SETTLE_CNT) begin
			settle_cnt_ff <= settle_cnt_ff + 11'h001;
		end
	end
	assign settled = (settle_cnt_ff == PWV_SETTLE_CNT);

	// Read mux; unmapped addresses read zero
	always_comb begin
		nxt_dat = 32'h0000_0000;
		unique case (reg_hit)
			FPEP_REG_CTRL: begin
				nxt_dat[3:0] = flash_control_reg_ff;
				nxt_dat[BIT_PROG_ACTIVE] = program_enable_o;
				nxt_dat[BIT_ERASE_ACTIVE] = erase_enable_o;
				nxt_dat[BIT_ABORTED] = abort_ff;
				nxt_dat[BIT_VPP_HIGH] = vpp_ok;
			end
			FPEP_REG_EBSU: nxt_dat[7:0] = erase_block_select_upper_ff;
			FPEP_REG_EBSL: nxt_dat[7:0] = erase_block_select_lower_ff;
			FPEP_REG_WSC: nxt_dat[7:0] = wait_state_control_reg_ff;
			FPEP_REG_STAT: begin
				nxt_dat[BIT_PREWRITE_VERIFY] = pwv_mode;
				nxt_dat[BIT_PREWRITE_SETTLED] = settled;
				nxt_dat[BIT_EMUL_PROTECT] = emul_protect;
			end
			default: nxt_dat = 32'h0000_0000;
		endcase
	end

	// One wait state on every access; ack drops after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
			dat_ff <= nxt_dat;
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// Checks
	property p_vpp_clears;
		@(posedge clk_i) disable iff (rst_i)
		!vpp_ok |=> (flash_control_reg_ff == 4'h0) && block_protect;
	endproperty
	a_vpp_clears: assert property (p_vpp_clears) else $error("regs kept on low vpp");

	property p_vpp_gates;
		@(posedge clk_i) disable iff (rst_i)
		!vpp_ok |-> !program_enable_o && !erase_enable_o && !program_verify_o &&
			!erase_verify_o && !prewrite_verify_o;
	endproperty
	a_vpp_gates: assert property (p_vpp_gates) else $error("mode on at low vpp");

	property p_reset_clears;
		@(posedge clk_i) (watchdog_reset_i || standby_i) |=>
			(flash_control_reg_ff == 4'h0) && block_protect;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("regs kept over reset");

	property p_reset_abort;
		@(posedge clk_i) watchdog_reset_i |=> !abort_ff;
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("abort kept over reset");

	property p_irq_aborts;
		@(posedge clk_i) disable iff (any_reset)
		irq_i && (program_enable_o || erase_enable_o) |=>
			abort_ff && !program_enable_o && !erase_enable_o;
	endproperty
	a_irq_aborts: assert property (p_irq_aborts) else $error("interrupt did not abort");

	property p_abort_sticky;
		@(posedge clk_i) disable iff (rst_i)
		abort_ff && !any_reset |=> abort_ff && !program_enable_o && !erase_enable_o;
	endproperty
	a_abort_sticky: assert property (p_abort_sticky) else $error("abort released early");

	property p_abort_keeps;
		@(posedge clk_i) disable iff (rst_i)
		abort_ff && !hw_clear |=> $stable(flash_control_reg_ff) && $stable(erase_block_select_lower_ff);
	endproperty
	a_abort_keeps: assert property (p_abort_keeps) else $error("regs changed after abort");

	property p_emul_blocks;
		@(posedge clk_i) disable iff (rst_i)
		(overlay_select_o == 2'h1 || overlay_select_o == 2'h2) |-> !program_enable_o && !erase_enable_o;
	endproperty
	a_emul_blocks: assert property (p_emul_blocks) else $error("emulation protect ignored");

	property p_block_sel;
		@(posedge clk_i) disable iff (rst_i)
		block_protect |-> !program_enable_o && !erase_enable_o && (block_enable_o == 16'h0000);
	endproperty
	a_block_sel: assert property (p_block_sel) else $error("unselected blocks enabled");

	property p_prewrite;
		@(posedge clk_i) disable iff (rst_i)
		prewrite_verify_o |-> (flash_control_reg_ff == 4'h0) && vpp_ok;
	endproperty
	a_prewrite: assert property (p_prewrite) else $error("prewrite verify wrongly on");

	property p_enable_terms;
		@(posedge clk_i) disable iff (rst_i)
		program_enable_o |-> flash_control_reg_ff[BIT_PROG] && vpp_ok && !abort_ff && !emul_protect;
	endproperty
	a_enable_terms: assert property (p_enable_terms) else $error("enable missing a term");

	c_program: cover property (@(posedge clk_i) disable iff (rst_i) program_enable_o);
	c_erase: cover property (@(posedge clk_i) disable iff (rst_i) erase_enable_o);
	c_abort: cover property (@(posedge clk_i) disable iff (rst_i) $rose(abort_ff));
	c_settle: cover property (@(posedge clk_i) disable iff (rst_i) $rose(settled));
endmodule : fpep_top
`default_nettype wire

// File: test/fpep_sw_model.sv
/* Software side model: issues classic Wishbone single cycles.
 * Assumes a slave that answers each access with one ack pulse. */
`timescale 1ns/1ps
`default_nettype none
module fpep_sw_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master side
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [3:0] sel_o,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i
);
	// Software timing counts at 250 MHz, scaled from the 10 MHz reference counts
	localparam int CLK_MHZ = 250;
	localparam int REF_MHZ = 10;
	localparam int PROG_CNT = (19 * CLK_MHZ) / REF_MHZ; // Pulse rounded down
	localparam int ERASE_CNT = (3906 * CLK_MHZ) / REF_MHZ; // Rounded down
	localparam int VFY1_CNT = (7 * CLK_MHZ + REF_MHZ - 1) / REF_MHZ; // Rounded up
	localparam int VFY2_CNT = (4 * CLK_MHZ + REF_MHZ - 1) / REF_MHZ; // Rounded up
	localparam int MAX_WRITES = 6; // Retry limit per location
	localparam int PROG_LIMIT_NS = 1000000; // Cumulative program time
	localparam int ERASE_LIMIT_MS = 30000; // Cumulative erase time
	// Guard code assumes a fixed instruction count between watchdog start and stop
	localparam logic [15:0] WDT_CODE = (CLK_MHZ >= REF_MHZ) ? 16'hA57F : 16'hA57E;
	// Bus idle from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	// Request held until ack is sampled, then a one cycle gap
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= {24'h0, wd};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rd = dat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		@(posedge clk_i);
	endtask : xfer
endmodule : fpep_sw_model
`default_nettype wire

// File: test/testbench.sv
/* Self-checking bench for the flash protection block.
 * Assumes the software model file is compiled before this one. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	import fpep_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cyc, stb, we, ack, vpp = 1'b1, clr_n = 1'b1;
	logic wdr = 1'b0, stby = 1'b0, irq = 1'b0, pe, ee, prog_vfy, erase_vfy, pwv;
	logic [3:0] sel;
	logic [7:0] adr, d;
	logic [31:0] dw, dr;
	logic [15:0] blk;
	logic [1:0] ovl;
	int num_errors = 0, checks_done = 0;
	fpep_top u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .program_voltage_pin_i(vpp), .chip_clear_pin_n_i(clr_n),
		.watchdog_reset_i(wdr), .standby_i(stby), .irq_i(irq), .program_enable_o(pe),
		.erase_enable_o(ee), .program_verify_o(prog_vfy), .erase_verify_o(erase_vfy),
		.prewrite_verify_o(pwv), .block_enable_o(blk), .overlay_select_o(ovl));
	fpep_sw_model u_sw (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(dw), .dat_i(dr), .ack_i(ack));
	// 250 MHz clock
	always #2 clk = ~clk;
	// Bus wrappers; the delay lets the ack edge settle before checks
	task wr(input logic [7:0] a, input logic [7:0] v);
		u_sw.xfer(1'b1, a, v, d);
		#1;
	endtask : wr
	task rd(input logic [7:0] a);
		u_sw.xfer(1'b0, a, 8'h00, d);
		#1;
	endtask : rd
	// One-cycle pulse on {standby, watchdog reset, interrupt}, one-hot select
	task pulse(input logic [2:0] which);
		@(posedge clk);
		{stby, wdr, irq} <= which;
		@(posedge clk);
		{stby, wdr, irq} <= 3'h0;
		#1;
	endtask : pulse
	task t_reset_vals;
		rd(OFS_FLASH_CTRL); `CHK(d, 8'h80)
		rd(OFS_WAIT_STATE); `CHK(d, 8'h08)
		wr(8'h14, 8'h5A);
		rd(8'h14); `CHK(d, 8'h00)
		`CHK(pwv, 1'b1)
	endtask : t_reset_vals
	task t_block;
		wr(OFS_FLASH_CTRL, 8'h04); `CHK(prog_vfy, 1'b1)
		wr(OFS_FLASH_CTRL, 8'h01); `CHK(pe, 1'b0)
		rd(OFS_FLASH_CTRL); `CHK(d, 8'h81)
		wr(OFS_EBS_LOWER, 8'h01); `CHK(pe, 1'b1)
		wr(OFS_EBS_UPPER, 8'h80); `CHK(blk, 16'h8001)
		rd(OFS_FLASH_CTRL); `CHK(d, 8'h91)
	endtask : t_block
	task t_emul;
		wr(OFS_WAIT_STATE, 8'h48); `CHK(pe, 1'b0)
		`CHK(ovl, 2'b01)
		rd(OFS_STATUS); `CHK(d[2], 1'b1)
		wr(OFS_WAIT_STATE, 8'h88); `CHK(pe, 1'b0)
		`CHK(ovl, 2'b10)
		wr(OFS_WAIT_STATE, 8'hC8); `CHK(pe, 1'b1)
		wr(OFS_WAIT_STATE, 8'h08);
	endtask : t_emul
	task t_modes;
		wr(OFS_FLASH_CTRL, 8'h02); `CHK({ee, pe}, 2'b10)
		wr(OFS_FLASH_CTRL, 8'h03); `CHK({ee, pe}, 2'b00)
		wr(OFS_FLASH_CTRL, 8'h08); `CHK({erase_vfy, prog_vfy, pwv}, 3'b100)
		wr(OFS_FLASH_CTRL, 8'h00); `CHK(pwv, 1'b1)
		rd(OFS_STATUS); `CHK(d[1:0], 2'b01)
		repeat (1010) @(posedge clk); // Settling wait, rounded up
		rd(OFS_STATUS); `CHK(d[1:0], 2'b11)
	endtask : t_modes
	// Program retry loop, prewrite verify and erase as software runs them
	task t_prog;
		int n;
		int total_ns;
		rd(OFS_WAIT_STATE); `CHK(d[1:0], 2'b00) // No wait states while programming
		for (n = 0; n < 2; n++) begin
			wr(OFS_FLASH_CTRL, 8'h01); `CHK(pe, 1'b1)
			repeat (u_sw.PROG_CNT) @(posedge clk); // Pulse count
			wr(OFS_FLASH_CTRL, 8'h04); `CHK({prog_vfy, pe}, 2'b10)
			repeat (u_sw.VFY2_CNT) @(posedge clk); // Verify settling
		end
		total_ns = n * u_sw.PROG_CNT * CLK_PERIOD_NS;
		`CHK(n <= u_sw.MAX_WRITES, 1'b1)
		`CHK(total_ns <= u_sw.PROG_LIMIT_NS, 1'b1)
		wr(OFS_FLASH_CTRL, 8'h00); `CHK(pwv, 1'b1) // Prewrite pass ends in verify
		wr(OFS_FLASH_CTRL, 8'h02); `CHK(ee, 1'b1) // Erase only after prewrite
		wr(OFS_FLASH_CTRL, 8'h00);
	endtask : t_prog
	task t_abort;
		wr(OFS_FLASH_CTRL, 8'h01); `CHK(pe, 1'b1)
		pulse(3'h1); `CHK(pe, 1'b0)
		rd(OFS_FLASH_CTRL); `CHK(d, 8'hC1)
		rd(OFS_EBS_LOWER); `CHK(d, 8'h01)
		wr(OFS_FLASH_CTRL, 8'h00);
		rd(OFS_FLASH_CTRL); `CHK(d, 8'hC1)
		pulse(3'h2);
		rd(OFS_FLASH_CTRL); `CHK(d, 8'h80)
		rd(OFS_EBS_LOWER); `CHK(d, 8'h00)
	endtask : t_abort
	task t_vpp;
		wr(OFS_EBS_LOWER, 8'h01);
		wr(OFS_FLASH_CTRL, 8'h01);
		@(posedge clk) vpp <= 1'b0;
		repeat (4) @(posedge clk);
		#1 `CHK({pe, pwv}, 2'b00)
		wr(OFS_EBS_LOWER, 8'h0F);
		rd(OFS_EBS_LOWER); `CHK(d, 8'h00)
		rd(OFS_FLASH_CTRL); `CHK(d, 8'h00)
		@(posedge clk) vpp <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : t_vpp
	task t_standby;
		wr(OFS_EBS_LOWER, 8'h01);
		wr(OFS_WAIT_STATE, 8'hC8);
		pulse(3'h4);
		rd(OFS_EBS_LOWER); `CHK(d, 8'h00)
		rd(OFS_WAIT_STATE); `CHK(d, 8'h08)
		wr(OFS_EBS_UPPER, 8'h02);
		@(posedge clk) clr_n <= 1'b0;
		repeat (10) @(posedge clk); // Pin held low ten clocks
		clr_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFS_EBS_UPPER); `CHK(d, 8'h00)
	endtask : t_standby
	task stop_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Main sequence after three reset cycles and synchroniser settling
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset_vals();
		t_block();
		t_emul();
		t_modes();
		t_prog();
		t_abort();
		t_vpp();
		t_standby();
		stop_test();
	end
	// Watchdog: the run needs about 2400 cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire
